/* File: pkg/bic_defines.vh */
// Constants of the binary input conditioner
`ifndef BIC_DEFINES_VH
`define BIC_DEFINES_VH

// ****************************************************************
// Register byte addresses
// ****************************************************************
`define BIC_ADDR_CTRL 6'h00
`define BIC_ADDR_FMAX 6'h04
`define BIC_ADDR_LRV 6'h08
`define BIC_ADDR_URV 6'h0C
`define BIC_ADDR_DAMP 6'h10
`define BIC_ADDR_NAME 6'h14
`define BIC_ADDR_UNIT 6'h18
`define BIC_ADDR_STAT 6'h1C
`define BIC_ADDR_FREQ 6'h20
`define BIC_ADDR_VALUE 6'h24

// ****************************************************************
// Control fields and reset values
// ****************************************************************
`define BIC_CTRL_EN 0
`define BIC_CTRL_PULSE 1
`define BIC_CTRL_POL_LOW 2
`define BIC_CTRL_SCALED 3
`define BIC_CTRL_DEC_HI 5
`define BIC_CTRL_DEC_LO 4
`define BIC_CTRL_MASK 32'h0000_003F
`define BIC_CTRL_RST 32'h0000_0021
`define BIC_STAT_OVER 2

// ****************************************************************
// Setting limits, values in hundredths, damping in whole seconds
// ****************************************************************
`define BIC_FMAX_MIN 32'h0000_2710
`define BIC_FMAX_MAX 32'h0001_86A0
`define BIC_FMAX_RST 32'h0001_86A0
`define BIC_LRV_MIN 32'hFFFC_F2C0
`define BIC_URV_MAX 32'h000F_4240
`define BIC_DAMP_MAX 32'h0000_0258

// ****************************************************************
// Timing
// ****************************************************************
`define BIC_CLK_MHZ 125
`define BIC_TIMEOUT_MS 2000
`define BIC_TICK_MS 10
`define BIC_TICKS_PER_S 28'h000_0064
`define BIC_FREQ_NUM (40'h00_0773_5940 * 40'h00_0000_0064)
`define BIC_MINP_RST 28'h001_E848
`define BIC_STEP_SHIFT 13
`define BIC_DIV_STEPS 6'h28

`endif

/* File: core/bic_sync.v */
// Two-stage synchroniser for the field input
`timescale 1ns/1ps
module bic_sync
(
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Data
    input wire d,
    output reg q
);
    reg meta;

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta <= 1'b0;
            q <= 1'b0;
        end
        else
        begin
            meta <= d;
            q <= meta;
        end
    end
endmodule

/* File: core/bic_div.v */
// Sequential restoring divider, one quotient bit per clock
`timescale 1ns/1ps
`include "bic_defines.vh"
module bic_div
(
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Request
    input wire start,
    input wire [39:0] num,
    input wire [27:0] den,
    // Result
    output reg done,
    output reg [39:0] quo
);
    reg [39:0] q;
    reg [28:0] r;
    reg [5:0] cnt;
    reg busy;
    wire [28:0] sh = {r[27:0], q[39]};
    wire [28:0] diff = sh - {1'b0, den};

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            q <= 40'h00_0000_0000;
            r <= 29'h0000_0000;
            cnt <= 6'h00;
            busy <= 1'b0;
            done <= 1'b0;
            quo <= 40'h00_0000_0000;
        end
        else if (start)
        begin
            q <= num;
            r <= 29'h0000_0000;
            cnt <= `BIC_DIV_STEPS;
            busy <= 1'b1;
            done <= 1'b0;
        end
        else if (busy)
        begin
            q <= {q[38:0], ~diff[28]};
            r <= diff[28] ? sh : diff;
            cnt <= cnt - 6'h01;
            if (cnt == 6'h01)
            begin
                busy <= 1'b0;
                done <= 1'b1;
                quo <= {q[38:0], ~diff[28]};
            end
        end
        else
        begin
            done <= 1'b0;
        end
    end
endmodule

/* File: core/bic_top.v */
// Binary input conditioner: static level and pulse-rate channel
//
// The plain strobed port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "bic_defines.vh"
module bic_top
#(
    parameter [27:0] TIMEOUT_CYC = `BIC_CLK_MHZ * 1000 * `BIC_TIMEOUT_MS,
    parameter [27:0] TICK_CYC = `BIC_CLK_MHZ * 1000 * `BIC_TICK_MS
)
(
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Field input
    input wire din,
    // Register port
    input wire [5:0] addr,
    input wire [31:0] wdata,
    input wire wr,
    input wire rd,
    output reg [31:0] rdata,
    // Results
    output reg active,
    output reg [16:0] freq,
    output reg [31:0] value,
    output reg value_upd
);
    // ****************************************************************
    // States
    // ****************************************************************
    localparam [8:0] S_IDLE = 9'h001;
    localparam [8:0] S_MINP = 9'h002;
    localparam [8:0] S_FREQ = 9'h004;
    localparam [8:0] S_QUANT = 9'h008;
    localparam [8:0] S_DAMP = 9'h010;
    localparam [8:0] S_SPREP = 9'h020;
    localparam [8:0] S_SCALE = 9'h040;
    localparam [8:0] S_FPREP = 9'h080;
    localparam [8:0] S_FMT = 9'h100;

    // ****************************************************************
    // Declarations
    // ****************************************************************
    reg [31:0] ctrl;
    reg [31:0] fmax;
    reg [31:0] lrv;
    reg [31:0] urv;
    reg [31:0] damp;
    reg [31:0] name_txt;
    reg [31:0] unit_txt;
    reg over;
    reg din_d;
    reg armed;
    reg [27:0] per_cnt;
    reg [27:0] per_last;
    reg [27:0] min_per;
    reg [27:0] tick_cnt;
    reg tick;
    reg [8:0] state;
    reg div_start;
    reg [39:0] div_num;
    reg [27:0] div_den;
    reg [16:0] avg;
    reg [16:0] f_q;
    reg up;
    reg neg;
    reg [31:0] v_lin;
    wire din_s;
    wire div_done;
    wire [39:0] div_quo;
    wire en = ctrl[`BIC_CTRL_EN];
    wire pulse = ctrl[`BIC_CTRL_PULSE];
    wire pol_low = ctrl[`BIC_CTRL_POL_LOW];
    wire scaled = ctrl[`BIC_CTRL_SCALED];
    wire [1:0] dec = ctrl[`BIC_CTRL_DEC_HI:`BIC_CTRL_DEC_LO];
    wire run = en & pulse;
    wire rise = din_s & ~din_d;
    wire [3:0] step = fmax[16:`BIC_STEP_SHIFT];
    wire [31:0] span = urv - lrv;
    wire [39:0] prod = {23'h00_0000, avg} * {8'h00, span};
    wire [27:0] damp_den = {18'h0_0000, damp[9:0]} * `BIC_TICKS_PER_S;
    wire [16:0] f_sat = (div_quo > {23'h00_0000, fmax[16:0]}) ? fmax[16:0] : div_quo[16:0];
    wire [16:0] f_stp = f_q * {13'h0000, step};
    wire [16:0] delta = (div_quo[16:0] == 17'h0_0000) ? 17'h0_0001 : div_quo[16:0];
    wire [31:0] v_abs = v_lin[31] ? (32'h0000_0000 - v_lin) : v_lin;

    bic_sync u_sync
    (
        .clk(clk),
        .rst_n(rst_n),
        .d(din),
        .q(din_s)
    );

    bic_div u_div
    (
        .clk(clk),
        .rst_n(rst_n),
        .start(div_start),
        .num(div_num),
        .den(div_den),
        .done(div_done),
        .quo(div_quo)
    );

    // ****************************************************************
    // Register writes with range clamping
    // ****************************************************************
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl <= `BIC_CTRL_RST;
            fmax <= `BIC_FMAX_RST;
            lrv <= 32'h0000_0000;
            urv <= 32'h0000_0000;
            damp <= 32'h0000_0000;
            name_txt <= 32'h0000_0000;
            unit_txt <= 32'h0000_0000;
        end
        else if (wr)
        begin
            case (addr)
                `BIC_ADDR_CTRL: ctrl <= wdata & `BIC_CTRL_MASK;
                `BIC_ADDR_FMAX:
                begin
                    if (wdata < `BIC_FMAX_MIN)
                        fmax <= `BIC_FMAX_MIN;
                    else if (wdata > `BIC_FMAX_MAX)
                        fmax <= `BIC_FMAX_MAX;
                    else
                        fmax <= wdata;
                end
                `BIC_ADDR_LRV:
                begin
                    if ($signed(wdata) < $signed(`BIC_LRV_MIN))
                        lrv <= `BIC_LRV_MIN;
                    else if ($signed(wdata) > 0)
                        lrv <= 32'h0000_0000;
                    else
                        lrv <= wdata;
                end
                `BIC_ADDR_URV:
                begin
                    if (wdata[31])
                        urv <= 32'h0000_0000;
                    else if (wdata > `BIC_URV_MAX)
                        urv <= `BIC_URV_MAX;
                    else
                        urv <= wdata;
                end
                `BIC_ADDR_DAMP: damp <= (wdata > `BIC_DAMP_MAX) ? `BIC_DAMP_MAX : wdata;
                `BIC_ADDR_NAME: name_txt <= wdata;
                `BIC_ADDR_UNIT: unit_txt <= wdata;
                default: ctrl <= ctrl;
            endcase
        end
    end

    // ****************************************************************
    // Register reads, data valid the cycle after the strobe
    // ****************************************************************
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdata <= 32'h0000_0000;
        end
        else if (rd)
        begin
            case (addr)
                `BIC_ADDR_CTRL: rdata <= ctrl;
                `BIC_ADDR_FMAX: rdata <= fmax;
                `BIC_ADDR_LRV: rdata <= lrv;
                `BIC_ADDR_URV: rdata <= urv;
                `BIC_ADDR_DAMP: rdata <= damp;
                `BIC_ADDR_NAME: rdata <= name_txt;
                `BIC_ADDR_UNIT: rdata <= unit_txt;
                `BIC_ADDR_STAT: rdata <= {29'h0000_0000, over, din_s, active};
                `BIC_ADDR_FREQ: rdata <= {15'h0000, freq};
                `BIC_ADDR_VALUE: rdata <= value;
                default: rdata <= 32'h0000_0000;
            endcase
        end
        else
        begin
            rdata <= 32'h0000_0000;
        end
    end

    // ****************************************************************
    // Static level path
    // ****************************************************************
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            active <= 1'b0;
            din_d <= 1'b0;
        end
        else
        begin
            din_d <= din_s;
            active <= en & ~pulse & (din_s ^ pol_low);
        end
    end

    // ****************************************************************
    // Period measurement with overrange rejection
    // ****************************************************************
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            per_cnt <= 28'h000_0000;
            per_last <= 28'h000_0000;
            armed <= 1'b0;
            over <= 1'b0;
        end
        else
        begin
            // Overrange flag: a new event beats a clear in the same cycle
            if (run && armed && rise && per_cnt < min_per)
                over <= 1'b1;
            else if (wr && addr == `BIC_ADDR_STAT && wdata[`BIC_STAT_OVER])
                over <= 1'b0;
            if (!run)
            begin
                per_cnt <= 28'h000_0000;
                per_last <= 28'h000_0000;
                armed <= 1'b0;
            end
            else if (rise && !armed)
            begin
                armed <= 1'b1;
                per_cnt <= 28'h000_0001;
            end
            else if (rise && per_cnt >= min_per)
            begin
                per_last <= per_cnt;
                per_cnt <= 28'h000_0001;
            end
            else if (per_cnt >= TIMEOUT_CYC)
            begin
                per_last <= 28'h000_0000;
                armed <= 1'b0;
            end
            else if (armed)
            begin
                per_cnt <= per_cnt + 28'h000_0001;
            end
        end
    end

    // ****************************************************************
    // Update tick
    // ****************************************************************
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tick_cnt <= 28'h000_0000;
            tick <= 1'b0;
        end
        else if (tick_cnt >= TICK_CYC - 28'h000_0001)
        begin
            tick_cnt <= 28'h000_0000;
            tick <= 1'b1;
        end
        else
        begin
            tick_cnt <= tick_cnt + 28'h000_0001;
            tick <= 1'b0;
        end
    end

    // ****************************************************************
    // Value pipeline: frequency, resolution, damping, scaling, format
    // ****************************************************************
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= S_IDLE;
            div_start <= 1'b0;
            div_num <= 40'h00_0000_0000;
            div_den <= 28'h000_0001;
            min_per <= `BIC_MINP_RST;
            avg <= 17'h0_0000;
            f_q <= 17'h0_0000;
            up <= 1'b0;
            neg <= 1'b0;
            v_lin <= 32'h0000_0000;
            freq <= 17'h0_0000;
            value <= 32'h0000_0000;
            value_upd <= 1'b0;
        end
        else if (!run)
        begin
            state <= S_IDLE;
            div_start <= 1'b0;
            avg <= 17'h0_0000;
            freq <= 17'h0_0000;
            value <= 32'h0000_0000;
            value_upd <= 1'b0;
        end
        else
        begin
            div_start <= 1'b0;
            value_upd <= 1'b0;
            case (state)
                S_IDLE:
                begin
                    if (tick)
                    begin
                        div_num <= `BIC_FREQ_NUM;
                        div_den <= {11'h000, fmax[16:0]};
                        div_start <= 1'b1;
                        state <= S_MINP;
                    end
                end
                S_MINP:
                begin
                    if (div_done)
                    begin
                        min_per <= div_quo[27:0];
                        div_num <= (per_last == 28'h000_0000) ? 40'h00_0000_0000 : `BIC_FREQ_NUM;
                        div_den <= (per_last == 28'h000_0000) ? 28'h000_0001 : per_last;
                        div_start <= 1'b1;
                        state <= S_FREQ;
                    end
                end
                S_FREQ:
                begin
                    if (div_done)
                    begin
                        div_num <= {23'h00_0000, f_sat};
                        div_den <= {24'h00_0000, step};
                        div_start <= 1'b1;
                        state <= S_QUANT;
                    end
                end
                S_QUANT:
                begin
                    if (div_done)
                    begin
                        f_q <= div_quo[16:0];
                        state <= S_DAMP;
                    end
                end
                S_DAMP:
                begin
                    if (damp == 32'h0000_0000)
                    begin
                        avg <= f_stp;
                        state <= S_SPREP;
                    end
                    else if (!div_start && f_stp == avg)
                    begin
                        state <= S_SPREP;
                    end
                    else if (!div_start && !up && !neg)
                    begin
                        up <= (f_stp > avg);
                        neg <= 1'b1;
                        div_num <= {23'h00_0000, (f_stp > avg) ? f_stp - avg : avg - f_stp};
                        div_den <= damp_den;
                        div_start <= 1'b1;
                    end
                    else if (div_done)
                    begin
                        avg <= up ? avg + delta : avg - delta;
                        up <= 1'b0;
                        neg <= 1'b0;
                        state <= S_SPREP;
                    end
                end
                S_SPREP:
                begin
                    freq <= avg;
                    if (scaled)
                    begin
                        div_num <= prod;
                        div_den <= {11'h000, fmax[16:0]};
                        div_start <= 1'b1;
                        state <= S_SCALE;
                    end
                    else
                    begin
                        v_lin <= {15'h0000, avg};
                        state <= S_FPREP;
                    end
                end
                S_SCALE:
                begin
                    if (div_done)
                    begin
                        v_lin <= lrv + div_quo[31:0];
                        state <= S_FPREP;
                    end
                end
                S_FPREP:
                begin
                    if (dec == 2'h2)
                    begin
                        value <= v_lin;
                        value_upd <= 1'b1;
                        state <= S_IDLE;
                    end
                    else if (dec == 2'h3)
                    begin
                        value <= {v_lin[28:0], 3'h0} + {v_lin[30:0], 1'b0};
                        value_upd <= 1'b1;
                        state <= S_IDLE;
                    end
                    else
                    begin
                        neg <= v_lin[31];
                        div_num <= {8'h00, v_abs};
                        div_den <= (dec == 2'h0) ? 28'h000_0064 : 28'h000_000A;
                        div_start <= 1'b1;
                        state <= S_FMT;
                    end
                end
                S_FMT:
                begin
                    if (div_done)
                    begin
                        value <= neg ? 32'h0000_0000 - div_quo[31:0] : div_quo[31:0];
                        neg <= 1'b0;
                        value_upd <= 1'b1;
                        state <= S_IDLE;
                    end
                end
                default:
                begin
                    state <= S_IDLE;
                end
            endcase
        end
    end
endmodule

/* File: tb/bic_top_monitor.sv */
// Port checker for the binary input conditioner
`timescale 1ns/1ps
`include "bic_defines.vh"
module bic_top_monitor
(
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Field input and register port
    input wire din,
    input wire [5:0] addr,
    input wire [31:0] wdata,
    input wire wr,
    input wire rd,
    input wire [31:0] rdata,
    // Results
    input wire active,
    input wire [16:0] freq,
    input wire [31:0] value,
    input wire value_upd
);
    reg [5:0] ctrl;
    reg [31:0] fmax;
    // ****
    // Shadow settings
    // ****
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl <= 6'h21;
            fmax <= `BIC_FMAX_RST;
        end
        else if (wr && addr == `BIC_ADDR_CTRL)
            ctrl <= wdata[5:0];
        else if (wr && addr == `BIC_ADDR_FMAX)
            fmax <= (wdata < `BIC_FMAX_MIN) ? `BIC_FMAX_MIN :
                (wdata > `BIC_FMAX_MAX) ? `BIC_FMAX_MAX : wdata;
    end
    // ****
    // Assertions
    // ****
    default clocking mon_clk @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    sequence s_off;
        !ctrl[0] [*4];
    endsequence
    sequence s_level_steady;
        (ctrl[0] && !ctrl[1] && $stable(din) && $stable(ctrl)) [*4];
    endsequence
    a_off_quiet: assert property (
        s_off |-> !active && freq == 17'h0_0000 && value == 32'h0000_0000)
        else $error("Switched-off channel shows activity");
    a_pulse_no_level: assert property (
        ctrl[1] [*4] |-> !active) else $error("Active level in pulse mode");
    a_static_level: assert property (
        s_level_steady |-> active == (din ^ ctrl[2])) else $error("Wrong active level");
    a_ctrl_read: assert property (
        rd && addr == `BIC_ADDR_CTRL |=> rdata == {26'h000_0000, $past(ctrl)})
        else $error("Control read-back wrong");
    a_fmax_read: assert property (
        rd && addr == `BIC_ADDR_FMAX |=> rdata == $past(fmax))
        else $error("Maximum frequency read-back wrong");
    a_stat_active: assert property (
        rd && addr == `BIC_ADDR_STAT |=> rdata[0] == $past(active))
        else $error("Status active bit wrong");
    a_upd_single: assert property (
        value_upd |=> !value_upd) else $error("Update pulse too long");
    a_freq_cap: assert property (
        value_upd |-> {15'h0000, freq} <= fmax) else $error("Frequency above maximum");
    a_raw_value: assert property (
        value_upd && ctrl == 6'h23 |-> value == {15'h0000, freq})
        else $error("Raw value differs from frequency");
endmodule

/* File: tb/bic_field_src.sv */
// Field source model: static contact or pulse-emitting meter
`timescale 1ns/1ps
module bic_field_src
(
    // Clock
    input wire clk,
    // Control
    input wire run,
    input wire [31:0] period,
    input wire lvl,
    // Field line
    output logic din
);
    int cnt = 0;
    // ****
    // Four-cycle pulses every period cycles, else the contact level
    // ****
    always @(posedge clk)
    begin
        if (!run)
        begin
            cnt <= 0;
            din <= lvl;
        end
        else
        begin
            cnt <= (cnt + 1 >= period) ? 0 : cnt + 1;
            din <= (cnt < 4);
        end
    end
endmodule

/* File: tb/tb_bic_top.sv */
// Self-checking bench for the binary input conditioner
`timescale 1ns/1ps
`include "bic_defines.vh"
`define CHK(got, exp, msg) begin num_checks++; if ((got) !== (exp)) begin err_total++; \
    $display("CHECK FAILED t=%0t %s got %h", $time, msg, got); end end
module tb_bic_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [5:0] addr = 6'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic run = 1'b0;
    logic lvl = 1'b0;
    logic [31:0] period = 32'h0000_0064;
    logic rd_seen = 1'b0;
    logic din, active, value_upd;
    logic [16:0] freq;
    logic [31:0] rdata, value;
    logic [63:0] rq[$];
    logic [48:0] vq[$];
    int err_total = 0;
    int num_checks = 0;
    int seed = 79;
    logic [6:0] ta [14] = '{7'h00, 7'h04, 7'h08, 7'h0C, 7'h10, 7'h3C, 7'h44, 7'h44,
        7'h48, 7'h4C, 7'h4C, 7'h50, 7'h54, 7'h7C};
    logic [31:0] tw [14] = '{0, 0, 0, 0, 0, 0, 32'h0000_1388, 32'h0003_0D40,
        32'hFFFB_6C20, 32'h001E_8480, 32'hFFFF_FFFB, 32'h0000_03E8, 32'h1234_ABCD, 1};
    logic [31:0] te [14] = '{`BIC_CTRL_RST, `BIC_FMAX_RST, 0, 0, 0, 0, `BIC_FMAX_MIN,
        `BIC_FMAX_MAX, `BIC_LRV_MIN, `BIC_URV_MAX, 0, `BIC_DAMP_MAX, 32'h1234_ABCD, 0};
    logic [31:0] fc [4] = '{32'h0000_0003, 32'h0000_0033, 32'h0000_0013, 32'h0000_002B};
    // Expected values carry the FMAX>>13 resolution step: 100000 Hz/100 reads as 99996
    logic [31:0] fv [4] = '{32'h0000_03E7, 32'h000F_4218, 32'h0000_270F, 32'h0007_A108};

    bic_top #(.TIMEOUT_CYC(28'h003_0D40), .TICK_CYC(28'h000_07D0)) i_bic_top (.clk(clk),
        .rst_n(rst_n), .din(din), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .active(active), .freq(freq), .value(value), .value_upd(value_upd));
    bic_field_src i_bic_field_src (.clk(clk), .run(run), .period(period), .lvl(lvl),
        .din(din));

    initial forever #4 clk = ~clk;

    task automatic tally_and_finish;
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        wr <= w;
        rd <= !w;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd_chk(input logic [5:0] a, input logic [31:0] m, input logic [31:0] e);
        rq.push_back({m, e});
        bus(1'b0, a, 32'h0000_0000);
    endtask

    // Skips one update, then notes the result expected at the next one
    task automatic upd_chk(input logic [16:0] f, input logic [31:0] v);
        int n;
        n = 0;
        while (value_upd !== 1'b1 && n < 9000)
        begin
            @(posedge clk);
            n++;
        end
        @(posedge clk);
        vq.push_back({f, v});
        while (vq.size() > 0 && n < 18000)
        begin
            @(posedge clk);
            n++;
        end
        if (n >= 18000)
        begin
            err_total++;
            tally_and_finish();
        end
    endtask

    // ****
    // Result watcher
    // ****
    always @(posedge clk)
    begin
        if (rd_seen && rq.size() > 0)
        begin
            `CHK(rdata & rq[0][63:32], rq[0][31:0], "read data")
            void'(rq.pop_front());
        end
        if (value_upd === 1'b1 && vq.size() > 0)
        begin
            `CHK(freq, vq[0][48:32], "frequency")
            `CHK(value, vq[0][31:0], "value")
            void'(vq.pop_front());
        end
        rd_seen <= rd;
    end

    initial
    begin
        repeat (300000) @(posedge clk);
        err_total++;
        tally_and_finish();
    end

    initial
    begin
        logic [31:0] r;
        logic [5:0] c;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        // Reset values, clamping, free text and an unmapped place
        for (int i = 0; i < 14; i++)
        begin
            if (ta[i][6])
                bus(1'b1, ta[i][5:0], tw[i]);
            rd_chk(ta[i][5:0], 32'hFFFF_FFFF, te[i]);
        end
        // Static level, both polarities, switched off
        for (int i = 0; i < 12; i++)
        begin
            c = (i < 4) ? 6'h21 : (i < 8) ? 6'h25 : 6'h20;
            bus(1'b1, `BIC_ADDR_CTRL, {26'h000_0000, c});
            r = $random(seed);
            lvl <= r[0];
            repeat (6) @(posedge clk);
            rd_chk(`BIC_ADDR_STAT, 32'h0000_0001, {31'h0000_0000, c[0] & (lvl ^ c[2])});
        end
        lvl <= 1'b0;
        // Over-fast pulses are ignored and flagged
        bus(1'b1, `BIC_ADDR_DAMP, 32'h0000_0000);
        bus(1'b1, `BIC_ADDR_CTRL, 32'h0000_0023);
        run <= 1'b1;
        repeat (600) @(posedge clk);
        rd_chk(`BIC_ADDR_STAT, 32'h0000_0004, 32'h0000_0004);
        run <= 1'b0;
        bus(1'b1, `BIC_ADDR_CTRL, 32'h0000_0022);
        bus(1'b1, `BIC_ADDR_STAT, 32'h0000_0004);
        rd_chk(`BIC_ADDR_STAT, 32'h0000_0004, 32'h0000_0000);
        // Pulse train at the maximum frequency, then every format and scaling
        bus(1'b1, `BIC_ADDR_CTRL, 32'h0000_0023);
        period <= 32'h0001_E848;
        run <= 1'b1;
        repeat (126000) @(posedge clk);
        upd_chk(17'h1_869C, 32'h0001_869C);
        bus(1'b1, `BIC_ADDR_URV, 32'h0007_A120);
        bus(1'b1, `BIC_ADDR_LRV, 32'hFFFE_7960);
        for (int i = 0; i < 4; i++)
        begin
            bus(1'b1, `BIC_ADDR_CTRL, fc[i]);
            upd_chk(17'h1_869C, fv[i]);
        end
        bus(1'b1, `BIC_ADDR_NAME, 32'h5A5A_0F0F);
        upd_chk(17'h1_869C, 32'h0007_A108);
        bus(1'b1, `BIC_ADDR_CTRL, 32'h0000_002A);
        repeat (8) @(posedge clk);
        rd_chk(`BIC_ADDR_FREQ, 32'hFFFF_FFFF, 32'h0000_0000);
        rd_chk(`BIC_ADDR_VALUE, 32'hFFFF_FFFF, 32'h0000_0000);
        run <= 1'b0;
        tally_and_finish();
    end
endmodule

bind bic_top bic_top_monitor i_bic_top_monitor (.clk(clk), .rst_n(rst_n), .din(din),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .active(active),
    .freq(freq), .value(value), .value_upd(value_upd));
